// ### hw/fault_pkg.sv
// Package for the converter fault-protection sequencer: register map,
// field layout, timing constants and the state carried by each module.
// Assumes a 100 MHz system clock; all counts are derived from it here.
package fault_pkg;

    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int CNT_W = 20;

    // Least times round up to whole cycles
    function automatic int unsigned ceil_cycles(input int unsigned ns);
        return (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    endfunction : ceil_cycles

    localparam int unsigned OCP_TIME_NS = 1000000;
    localparam int unsigned OT_TIME_NS = 160000;
    localparam int unsigned HICCUP_TIME_NS = 5000000;
    localparam int unsigned STARTUP_TIME_NS = 1000000;
    localparam int unsigned NVM_TIME_NS = 5000000;
    localparam logic [CNT_W-1:0] OCP_CYCLES = CNT_W'(ceil_cycles(OCP_TIME_NS));
    localparam logic [CNT_W-1:0] OT_CYCLES = CNT_W'(ceil_cycles(OT_TIME_NS));
    localparam logic [CNT_W-1:0] HICCUP_CYCLES =
        CNT_W'(ceil_cycles(HICCUP_TIME_NS));
    localparam logic [CNT_W-1:0] STARTUP_CYCLES =
        CNT_W'(ceil_cycles(STARTUP_TIME_NS));
    localparam logic [CNT_W-1:0] NVM_CYCLES = CNT_W'(ceil_cycles(NVM_TIME_NS));

    // Register offsets
    localparam logic [7:0] ADDR_FAULT_STATUS = 8'h54;
    localparam logic [7:0] ADDR_NVM_PROGRAM = 8'h60;
    localparam logic [7:0] ADDR_NVM_UNLOCK_KEY = 8'h61;

    // Field layout
    localparam int FLT_SHORT = 2;
    localparam int FLT_OCP = 1;
    localparam int FLT_OT = 0;
    localparam int CMD_LSB = 3;
    localparam int CMD_MSB = 7;
    localparam int DONE_BIT = 1;
    localparam logic [4:0] NVM_PROGRAM_CODE = 5'h12;
    localparam logic [7:0] UNLOCK_KEY_VALUE = 8'h61;
    localparam logic PROG_RESV_BIT0 = 1'h1;
    localparam logic [7:0] UNLOCK_RESET = 8'h00;

    typedef enum logic [1:0] {PH_RESET, PH_START, PH_RUN, PH_HICCUP} phase_t;

    typedef struct packed {
        logic uvlo;
        logic ocp;
        logic short_ckt;
        logic overtemp;
    } fault_in_t;

    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic expired;
    } timer_t;

    typedef struct packed {
        phase_t phase;
        logic [CNT_W-1:0] cnt;
        logic [2:0] fault;
        logic oe;
        logic pg;
        logic por;
        logic [4:0] cmd;
        logic done;
        logic busy;
        logic [CNT_W-1:0] nvm_cnt;
        logic [7:0] key;
        logic [7:0] rdata;
    } ctrl_t;

    localparam ctrl_t CTRL_RESET = '{phase: PH_RESET, por: 1'b1,
        key: UNLOCK_RESET, default: '0};

endpackage : fault_pkg

// ### hw/fault_timer.sv
// Persistence timer: flags a fault level that has held for a set count.
// Assumes the level is synchronous to the clock; the count restarts on any
// gap, so a chattering fault never accumulates.
`timescale 1ns/1ps
module fault_timer (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic arm_in,
    input wire logic level_in,
    input wire logic [fault_pkg::CNT_W-1:0] limit_in,
    output logic expired_out
);
    fault_pkg::timer_t q;
    fault_pkg::timer_t d;

    always_comb
    begin
        d = q;
        if (!(arm_in && level_in))
        begin
            d = '0;
        end
        else if (!q.expired)
        begin
            if (q.cnt >= fault_pkg::CNT_W'(limit_in - 1'b1))
                d.expired = 1'b1;
            else
                d.cnt = fault_pkg::CNT_W'(q.cnt + 1'b1);
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            q <= '0;
        else
            q <= d;
    end

    assign expired_out = q.expired;

endmodule : fault_timer

// ### hw/converter_fault_protection.sv
// Fault-protection sequencer for a buck converter plus the guarded
// programming of non-volatile configuration memory.
// Assumes fault levels come from synchronous comparators and that the
// register port carries one synchronous write per cycle.
`timescale 1ns/1ps
module converter_fault_protection #(
    parameter logic [fault_pkg::CNT_W-1:0] OCP_LIMIT = fault_pkg::OCP_CYCLES,
    parameter logic [fault_pkg::CNT_W-1:0] OT_LIMIT = fault_pkg::OT_CYCLES,
    parameter logic [fault_pkg::CNT_W-1:0] HICCUP_LIMIT =
        fault_pkg::HICCUP_CYCLES,
    parameter logic [fault_pkg::CNT_W-1:0] STARTUP_LIMIT =
        fault_pkg::STARTUP_CYCLES,
    parameter logic [fault_pkg::CNT_W-1:0] NVM_LIMIT = fault_pkg::NVM_CYCLES
) (
    input wire logic mclk_in,
    input wire logic reset_n_in,
    input wire fault_pkg::fault_in_t faults_in,
    input wire fault_pkg::reg_req_t reg_req_in,
    output logic [7:0] reg_rdata_out,
    output logic output_enable_out,
    output logic power_good_output_out,
    output logic logic_reset_out,
    output logic nvm_program_busy_out
);
    logic [1:0] rst_sync_q;
    logic rst_n;
    logic ocp_expired;
    logic ot_expired;
    logic prog_start;
    logic prog_write;
    fault_pkg::ctrl_t q;
    fault_pkg::ctrl_t d;

    // Release of reset is synchronised; assertion stays asynchronous
    always_ff @(posedge mclk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            rst_sync_q <= 2'h0;
        else
            rst_sync_q <= {rst_sync_q[0], 1'h1};
    end
    assign rst_n = rst_sync_q[1];

    fault_timer u_ocp_timer (
        .clk_in(mclk_in),
        .rst_n_in(rst_n),
        .arm_in(q.oe),
        .level_in(faults_in.ocp),
        .limit_in(OCP_LIMIT),
        .expired_out(ocp_expired)
    );

    fault_timer u_ot_timer (
        .clk_in(mclk_in),
        .rst_n_in(rst_n),
        .arm_in(q.oe),
        .level_in(faults_in.overtemp),
        .limit_in(OT_LIMIT),
        .expired_out(ot_expired)
    );

    function automatic logic [7:0] read_reg(input logic [7:0] addr,
                                            input fault_pkg::ctrl_t s);
        logic [7:0] r;
        r = 8'h00;
        unique case (addr)
            fault_pkg::ADDR_FAULT_STATUS: r = {5'h00, s.fault};
            fault_pkg::ADDR_NVM_PROGRAM:
                r = {s.cmd, 1'h0, s.done, fault_pkg::PROG_RESV_BIT0};
            fault_pkg::ADDR_NVM_UNLOCK_KEY: r = s.key;
            default: r = 8'h00;
        endcase
        return r;
    endfunction : read_reg

    assign prog_write = reg_req_in.wr &&
        reg_req_in.addr == fault_pkg::ADDR_NVM_PROGRAM;
    assign prog_start = prog_write && !q.busy &&
        reg_req_in.wdata[fault_pkg::CMD_MSB:fault_pkg::CMD_LSB] ==
            fault_pkg::NVM_PROGRAM_CODE &&
        q.key == fault_pkg::UNLOCK_KEY_VALUE;

    always_comb
    begin
        d = q;
        d.por = 1'b0;
        unique case (q.phase)
            fault_pkg::PH_RESET:
            begin
                d.phase = fault_pkg::PH_START;
                d.oe = 1'b1;
                d.cnt = '0;
            end
            fault_pkg::PH_START, fault_pkg::PH_RUN:
            begin
                if (faults_in.short_ckt || ocp_expired || ot_expired)
                begin
                    // Short trips at once: it needs no persistence
                    d.phase = fault_pkg::PH_HICCUP;
                    d.oe = 1'b0;
                    d.pg = 1'b0;
                    d.cnt = '0;
                    d.fault[fault_pkg::FLT_SHORT] =
                        q.fault[fault_pkg::FLT_SHORT] | faults_in.short_ckt;
                    d.fault[fault_pkg::FLT_OCP] = q.fault[fault_pkg::FLT_OCP]
                        | ocp_expired;
                    d.fault[fault_pkg::FLT_OT] = q.fault[fault_pkg::FLT_OT]
                        | ot_expired;
                end
                else if (q.phase == fault_pkg::PH_START)
                begin
                    if (q.cnt >= fault_pkg::CNT_W'(STARTUP_LIMIT - 1'b1))
                    begin
                        d.phase = fault_pkg::PH_RUN;
                        d.pg = 1'b1;
                        d.fault = 3'h0;
                    end
                    else
                    begin
                        d.cnt = fault_pkg::CNT_W'(q.cnt + 1'b1);
                    end
                end
            end
            fault_pkg::PH_HICCUP:
            begin
                if (q.cnt < fault_pkg::CNT_W'(HICCUP_LIMIT - 1'b1))
                begin
                    d.cnt = fault_pkg::CNT_W'(q.cnt + 1'b1);
                end
                else if (!(q.fault[fault_pkg::FLT_OT] && faults_in.overtemp))
                begin
                    // Thermal cause waits for the hysteresis level to clear
                    d.phase = fault_pkg::PH_START;
                    d.oe = 1'b1;
                    d.cnt = '0;
                end
            end
        endcase

        // Programming cycle; the burn itself is outside this block
        if (q.busy)
        begin
            if (q.nvm_cnt >= fault_pkg::CNT_W'(NVM_LIMIT - 1'b1))
            begin
                d.busy = 1'b0;
                d.done = 1'b1;
            end
            else
            begin
                d.nvm_cnt = fault_pkg::CNT_W'(q.nvm_cnt + 1'b1);
            end
        end
        if (reg_req_in.wr &&
            reg_req_in.addr == fault_pkg::ADDR_NVM_UNLOCK_KEY)
            d.key = reg_req_in.wdata;
        if (prog_write)
            d.cmd = reg_req_in.wdata[fault_pkg::CMD_MSB:fault_pkg::CMD_LSB];
        if (prog_start)
        begin
            d.busy = 1'b1;
            d.done = 1'b0;
            d.nvm_cnt = '0;
        end
        d.rdata = read_reg(reg_req_in.addr, q);

        // Undervoltage overrides everything, including a pending program
        if (faults_in.uvlo)
            d = fault_pkg::CTRL_RESET;
    end

    always_ff @(posedge mclk_in or negedge rst_n)
    begin
        if (!rst_n)
            q <= fault_pkg::CTRL_RESET;
        else
            q <= d;
    end

    assign reg_rdata_out = q.rdata;
    assign output_enable_out = q.oe;
    assign power_good_output_out = q.pg;
    assign logic_reset_out = q.por;
    assign nvm_program_busy_out = q.busy;

    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!rst_n);

    sequence hiccup_over_s;
        q.phase == fault_pkg::PH_HICCUP && !faults_in.uvlo &&
        q.cnt >= fault_pkg::CNT_W'(HICCUP_LIMIT - 1'b1);
    endsequence

    sequence output_on_s;
        (q.phase == fault_pkg::PH_START || q.phase == fault_pkg::PH_RUN) &&
        !faults_in.uvlo;
    endsequence

    uvlo_reset_a: assert property (faults_in.uvlo |=>
        logic_reset_out && !output_enable_out && !power_good_output_out &&
        !nvm_program_busy_out)
        else $error("undervoltage did not reset logic");
    short_trip_a: assert property (
        output_on_s ##0 faults_in.short_ckt |=>
        !output_enable_out && !power_good_output_out)
        else $error("short did not shut output");
    ocp_trip_a: assert property (
        output_on_s ##0 ocp_expired |=>
        q.phase == fault_pkg::PH_HICCUP && !power_good_output_out)
        else $error("overload did not enter hiccup");
    ot_trip_a: assert property (
        output_on_s ##0 ot_expired |=>
        !output_enable_out && q.fault[fault_pkg::FLT_OT])
        else $error("overtemperature did not shut output");
    hiccup_retry_a: assert property (hiccup_over_s ##0
        !q.fault[fault_pkg::FLT_OT] |=>
        q.phase == fault_pkg::PH_START && output_enable_out)
        else $error("hiccup did not retry startup");
    ot_hold_a: assert property (hiccup_over_s ##0
        q.fault[fault_pkg::FLT_OT] && faults_in.overtemp |=>
        !output_enable_out)
        else $error("output restarted while still hot");
    resume_run_a: assert property (
        q.phase == fault_pkg::PH_START &&
        !faults_in.uvlo && !faults_in.short_ckt && !ocp_expired &&
        !ot_expired && q.cnt >= fault_pkg::CNT_W'(STARTUP_LIMIT - 1'b1) |=>
        power_good_output_out && q.fault == 3'h0)
        else $error("startup did not return to regulation");
    prog_clear_a: assert property (
        prog_start && !faults_in.uvlo |=>
        !q.done && nvm_program_busy_out)
        else $error("program start did not clear done");
    locked_a: assert property (prog_write && !q.busy &&
        q.key != fault_pkg::UNLOCK_KEY_VALUE |=> !nvm_program_busy_out)
        else $error("locked memory began programming");

endmodule : converter_fault_protection

// ### sim/test_converter_fault_protection.sv
// Self-checking bench for the converter fault-protection sequencer.
// Assumes the design is built with the short counts below.
`timescale 1ns/1ps
module test_converter_fault_protection;
    localparam logic [19:0] OCP_L = 20'h14;
    localparam logic [19:0] OT_L = 20'ha;
    localparam logic [19:0] HIC_L = 20'h8;
    localparam logic [19:0] STA_L = 20'h6;
    localparam logic [19:0] NVM_L = 20'h5;
    localparam logic [2:0] S_RD = 3'h0;
    localparam logic [2:0] S_OE = 3'h1;
    localparam logic [2:0] S_PG = 3'h2;
    localparam logic [2:0] S_POR = 3'h3;
    localparam logic [2:0] S_BUSY = 3'h4;
    typedef struct packed {logic [2:0] sel; logic [7:0] val;} note_t;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    fault_pkg::fault_in_t flt = '0;
    fault_pkg::reg_req_t req = '0;
    logic [7:0] rdata;
    logic oe, pg, por, busy;
    logic [31:0] seed = 32'hd1bd036d;
    logic [31:0] r;
    logic [7:0] k;
    logic [4:0] code;
    note_t notes[$];
    note_t n;
    int num_errors = 0;
    int checks = 0;

    converter_fault_protection #(
        .OCP_LIMIT(OCP_L),
        .OT_LIMIT(OT_L),
        .HICCUP_LIMIT(HIC_L),
        .STARTUP_LIMIT(STA_L),
        .NVM_LIMIT(NVM_L)
    ) uut (
        .mclk_in(clk),
        .reset_n_in(rst_n),
        .faults_in(flt),
        .reg_req_in(req),
        .reg_rdata_out(rdata),
        .output_enable_out(oe),
        .power_good_output_out(pg),
        .logic_reset_out(por),
        .nvm_program_busy_out(busy)
    );

    initial
    begin
        forever #5 clk = ~clk;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    function automatic logic [7:0] seen(input logic [2:0] sel);
        case (sel)
            S_RD: return rdata;
            S_OE: return {7'h0, oe};
            S_PG: return {7'h0, pg};
            S_POR: return {7'h0, por};
            default: return {7'h0, busy};
        endcase
    endfunction : seen

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] %0t: saw %h, expected %h", $time, got, exp);
        end
    endtask : check

    // Outputs are registered, so a note taken at a falling edge is settled
    initial
    begin
        forever
        begin
            wait (notes.size() != 0);
            n = notes.pop_front();
            check(seen(n.sel), n.val);
        end
    end

    task automatic cyc(input int c);
        repeat (c) @(negedge clk);
    endtask : cyc

    task automatic want(input logic [2:0] sel, input logic [7:0] val);
        notes.push_back('{sel: sel, val: val});
    endtask : want

    task automatic wait_for(input logic [2:0] sel, input logic [7:0] val,
        input int lim);
        int i;
        i = 0;
        while (seen(sel) !== val && i < lim)
        begin
            cyc(1);
            i++;
        end
        want(sel, val);
    endtask : wait_for

    // Write strobe stays up until idle or rd, so back-to-back writes never glitch
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        req = '{wr: 1'b1, addr: a, wdata: d};
        cyc(1);
    endtask : wr

    task automatic idle();
        req.wr = 1'b0;
    endtask : idle

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        req = '{wr: 1'b0, addr: a, wdata: 8'h00};
        cyc(1);
        want(S_RD, exp);
    endtask : rd

    task automatic end_sim();
        #1;
        $display("checks %0d, errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_sim

    initial
    begin
        #100000;
        num_errors++;
        end_sim();
    end

    initial
    begin
        cyc(4);
        want(S_POR, 8'h01);
        want(S_OE, 8'h00);
        want(S_PG, 8'h00);
        want(S_BUSY, 8'h00);
        rst_n = 1'b1;
        wait_for(S_OE, 8'h01, 4);
        want(S_POR, 8'h00);
        want(S_PG, 8'h00);
        wait_for(S_PG, 8'h01, STA_L + 4);
        rd(8'h60, 8'h01);
        rd(8'h61, 8'h00);
        rd(8'h54, 8'h00);
        rd(8'h33, 8'h00);
        r = rnd();
        k = (r[7:0] == 8'h61) ? 8'h60 : r[7:0];
        wr(8'h61, k);
        rd(8'h61, k);
        wr(8'h60, 8'h90);
        rd(8'h60, 8'h91);
        want(S_BUSY, 8'h00);
        wr(8'h61, 8'h61);
        wr(8'h60, 8'h90);
        want(S_BUSY, 8'h01);
        // A second command while busy must not restart the cycle
        wr(8'h60, 8'h90);
        rd(8'h60, 8'h91);
        cyc(NVM_L - 3);
        want(S_BUSY, 8'h01);
        cyc(1);
        want(S_BUSY, 8'h00);
        rd(8'h60, 8'h93);
        repeat (3)
        begin
            r = rnd();
            code = (r[4:0] == 5'h12) ? 5'h13 : r[4:0];
            wr(8'h60, {code, 3'h0});
            idle();
            cyc(1);
            want(S_BUSY, 8'h00);
            rd(8'h60, {code, 3'h3});
        end
        // Short trips at once and re-trips each restart while it lasts
        flt.short_ckt = 1'b1;
        cyc(1);
        want(S_OE, 8'h00);
        want(S_PG, 8'h00);
        rd(8'h54, 8'h04);
        wait_for(S_OE, 8'h01, HIC_L + 3);
        want(S_PG, 8'h00);
        wait_for(S_OE, 8'h00, 3);
        flt.short_ckt = 1'b0;
        wait_for(S_PG, 8'h01, HIC_L + STA_L + 8);
        rd(8'h54, 8'h00);
        // A gap in the overload restarts its persistence count
        flt.ocp = 1'b1;
        cyc(OCP_L - 2);
        flt.ocp = 1'b0;
        cyc(1);
        flt.ocp = 1'b1;
        cyc(OCP_L - 1);
        want(S_OE, 8'h01);
        wait_for(S_OE, 8'h00, 3);
        want(S_PG, 8'h00);
        rd(8'h54, 8'h02);
        wait_for(S_OE, 8'h01, HIC_L + 3);
        wait_for(S_OE, 8'h00, OCP_L + 3);
        flt.ocp = 1'b0;
        wait_for(S_PG, 8'h01, HIC_L + STA_L + 8);
        flt.overtemp = 1'b1;
        cyc(OT_L - 1);
        want(S_OE, 8'h01);
        wait_for(S_OE, 8'h00, 3);
        want(S_PG, 8'h00);
        rd(8'h54, 8'h01);
        cyc(HIC_L + STA_L);
        want(S_OE, 8'h00);
        flt.overtemp = 1'b0;
        wait_for(S_OE, 8'h01, 4);
        wait_for(S_PG, 8'h01, STA_L + 4);
        // Undervoltage in mid-programming drops the cycle and the key
        wr(8'h61, 8'h61);
        wr(8'h60, 8'h90);
        idle();
        want(S_BUSY, 8'h01);
        flt.uvlo = 1'b1;
        cyc(1);
        want(S_POR, 8'h01);
        want(S_OE, 8'h00);
        want(S_BUSY, 8'h00);
        flt.uvlo = 1'b0;
        rd(8'h61, 8'h00);
        want(S_POR, 8'h00);
        rd(8'h60, 8'h01);
        wait_for(S_OE, 8'h01, 4);
        rst_n = 1'b0;
        #1;
        want(S_POR, 8'h01);
        want(S_OE, 8'h00);
        cyc(2);
        rst_n = 1'b1;
        wait_for(S_OE, 8'h01, 4);
        end_sim();
    end
endmodule : test_converter_fault_protection
